// file: hdl/pcl_top.sv
/*
  pcl_top: pll control register with its write qualification, an
  ahb-lite slave for software, and the control levels it steers.
  assumes: mode inputs come from clock generator logic on mclk; the
  crystal failure and vco near-target levels come from analog logic
  and are synchronised here.
*/
// Chosen here: the register offsets and register access over AHB-Lite.
// Behaviour
// - monitor enable bit 7 writable anytime except while limp clock is active.
// - enabled monitor reacts to a failed crystal by reset or limp clock entry.
// - in full stop without oscillator, the monitor is off regardless of bit 7.
// - pll power bit 6 ignores writes while pll drives the system clock.
// - limp clock mode forces the pll on; bit 6 reads its latched value.
// - power on with automatic bandwidth lets the pll lock on its own.
// - automatic bit 5 set picks the filter from vco nearness, ignoring bit 4.
// - writes to the automatic bit are ignored while pll halt in wait is set.
// - with automatic off, bit 4 picks the filter: 1 wide, 0 narrow.
// - bit 2 keeps the tick divider running in pseudo-stop, else it stops.
// - stopped tick divider holds its count in pseudo-stop, no reinitialise.
// - bit 1 keeps the watchdog divider running in pseudo-stop, else it stops.
// - stopped watchdog divider holds its count in pseudo-stop, no reinitialise.
// - limp enable bit 0 write-once in normal modes, anytime in special; no clear in limp.
// - crystal failure gives monitor reset if bit 0 is 0, limp clock entry if 1.
// - pll halt in wait forces the automatic bit to 1.
// - pseudo-stop is stop with the oscillator kept running.
`timescale 1ns/1ps
`default_nettype none

module pcl_top
  import pcl_pkg::*;
(
  input  wire logic                              mclk,
  input  wire logic                              reset,
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output var  logic [31:0]                       hrdata,
  output var  logic                              hreadyout,
  output var  logic                              hresp,
  input  wire logic                              limpClockActive,
  input  wire logic                              pllAsSystemClock,
  input  wire logic                              pllHaltInWait,
  input  wire logic                              oscKeepInStop,
  input  wire logic                              stopActive,
  input  wire logic                              specialMode,
  input  wire logic                              crystalFailAsync,
  input  wire logic                              vcoNearTargetAsync,
  output var  logic                              pllPowerOut,
  output var  logic                              wideFilterOut,
  output var  logic                              autoBandwidthOut,
  output var  logic                              tickDividerRun,
  output var  logic                              watchdogDividerRun,
  output var  logic                              monitorActive,
  output var  logic                              monitorResetReq,
  output var  logic                              limpEnterReq
);

  import pcl_pkg::*;

  // ==========================================================
  // state
  typedef struct packed
  {
    logic [7:0]            ctrl;
    logic                  limpWritten;
    logic                  wrPend;
    logic [PCL_ADDR_W-1:0] wrAddr;
    logic [31:0]           rdata;
    logic                  pllPower;
    logic                  wideFilter;
    logic                  autoBw;
    logic                  tickRun;
    logic                  wdogRun;
  } pcl_top_state_t;

  pcl_top_state_t state_reg;
  pcl_top_state_t state_next;

  logic       failSync;
  logic       nearSync;
  logic       monActiveInt;
  logic       monResetInt;
  logic       limpReqInt;
  logic       addrPhase;
  logic       wrCtrl;
  logic       pseudoStop;
  logic [7:0] wdata;
  logic [7:0] ctrlNew;
  logic [7:0] status;

  // ==========================================================
  // synchronisers for analog levels
  pcl_sync2 u_failSync
  (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn (crystalFailAsync),
    .syncOut (failSync)
  );

  pcl_sync2 u_nearSync
  (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn (vcoNearTargetAsync),
    .syncOut (nearSync)
  );

  // ==========================================================
  // clock monitor and failure reaction
  pcl_fail_action u_failAction
  (
    .mclk            (mclk),
    .reset           (reset),
    .failSync        (failSync),
    .monitorEnable   (state_reg.ctrl[PCL_CME_BIT]),
    .stopActive      (stopActive),
    .oscKeepInStop   (oscKeepInStop),
    .limpEnable      (state_reg.ctrl[PCL_LIMP_BIT]),
    .limpActive      (limpClockActive),
    .monitorActive   (monActiveInt),
    .monitorResetReq (monResetInt),
    .limpEnterReq    (limpReqInt)
  );

  // ==========================================================
  // register update, bus and control levels
  always_comb
  begin
    state_next = state_reg;
    addrPhase  = hsel && hready && (htrans == PCL_HTRANS_NONSEQ || htrans == PCL_HTRANS_SEQ);
    wrCtrl     = state_reg.wrPend && pcl_hit(state_reg.wrAddr, PCL_CTRL_OFFSET);
    wdata      = hwdata[7:0];
    ctrlNew    = state_reg.ctrl;
    pseudoStop = stopActive && oscKeepInStop;

    // data phase of a write
    if (wrCtrl)
    begin
      if (!limpClockActive)
        ctrlNew[PCL_CME_BIT] = wdata[PCL_CME_BIT];
      if (!pllAsSystemClock)
        ctrlNew[PCL_PLL_POWER_ON_BIT] = wdata[PCL_PLL_POWER_ON_BIT];
      if (!pllHaltInWait)
        ctrlNew[PCL_AUTO_BIT] = wdata[PCL_AUTO_BIT];
      ctrlNew[PCL_ACQ_BIT]  = wdata[PCL_ACQ_BIT];
      ctrlNew[PCL_TICK_BIT] = wdata[PCL_TICK_BIT];
      ctrlNew[PCL_WDOG_BIT] = wdata[PCL_WDOG_BIT];
      if ((specialMode || !state_reg.limpWritten)
          && !(limpClockActive && !wdata[PCL_LIMP_BIT]))
        ctrlNew[PCL_LIMP_BIT] = wdata[PCL_LIMP_BIT];
      if (!specialMode)
        state_next.limpWritten = 1'b1;
    end
    if (pllHaltInWait)
      ctrlNew[PCL_AUTO_BIT] = 1'b1;
    ctrlNew          = ctrlNew & PCL_CTRL_MASK;
    state_next.ctrl  = ctrlNew;

    // address phase capture
    state_next.wrPend = addrPhase && hwrite;
    if (addrPhase)
      state_next.wrAddr = haddr[PCL_ADDR_W-1:0];

    status = '0;
    status[PCL_ST_LIMP_ACTIVE]  = limpClockActive;
    status[PCL_ST_PLL_SYSCLK]   = pllAsSystemClock;
    status[PCL_ST_HALT_WAIT]    = pllHaltInWait;
    status[PCL_ST_OSC_KEEP]     = oscKeepInStop;
    status[PCL_ST_STOP]         = stopActive;
    status[PCL_ST_NEAR]         = nearSync;
    status[PCL_ST_MON_ACTIVE]   = monActiveInt;
    status[PCL_ST_LIMP_WRITTEN] = state_next.limpWritten;

    // read data is taken in the address phase from the updated state
    if (addrPhase && !hwrite)
    begin
      if (pcl_hit(haddr[PCL_ADDR_W-1:0], PCL_CTRL_OFFSET))
        state_next.rdata = {24'h000000, ctrlNew};
      else if (pcl_hit(haddr[PCL_ADDR_W-1:0], PCL_STATUS_OFFSET))
        state_next.rdata = {24'h000000, status};
      else
        state_next.rdata = 32'h00000000;
    end

    // control levels toward the pll and dividers
    state_next.pllPower = state_reg.ctrl[PCL_PLL_POWER_ON_BIT] || limpClockActive;
    state_next.autoBw   = state_reg.ctrl[PCL_AUTO_BIT];
    if (state_reg.ctrl[PCL_AUTO_BIT])
      state_next.wideFilter = !nearSync;
    else
      state_next.wideFilter = state_reg.ctrl[PCL_ACQ_BIT];
    state_next.tickRun = !(pseudoStop && !state_reg.ctrl[PCL_TICK_BIT]);
    state_next.wdogRun = !(pseudoStop && !state_reg.ctrl[PCL_WDOG_BIT]);
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_reg             <= '0;
      state_reg.ctrl        <= PCL_CTRL_RESET;
      state_reg.limpWritten <= 1'b0;
      state_reg.pllPower    <= 1'b1;
      state_reg.autoBw      <= 1'b1;
      state_reg.wideFilter  <= 1'b1;
      state_reg.tickRun     <= 1'b1;
      state_reg.wdogRun     <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // ==========================================================
  // outputs
  assign hrdata             = state_reg.rdata;
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign pllPowerOut        = state_reg.pllPower;
  assign wideFilterOut      = state_reg.wideFilter;
  assign autoBandwidthOut   = state_reg.autoBw;
  assign tickDividerRun     = state_reg.tickRun;
  assign watchdogDividerRun = state_reg.wdogRun;
  assign monitorActive      = monActiveInt;
  assign monitorResetReq    = monResetInt;
  assign limpEnterReq       = limpReqInt;

endmodule

`default_nettype wire

// file: hdl/pcl_pkg.sv
/*
  pcl_pkg: register offsets, field positions and reset values of the
  pll control register block.
  assumes: a 32-bit ahb-lite register bus, one aligned word per register.
*/
`default_nettype none

package pcl_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] PCL_CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] PCL_STATUS_OFFSET = 12'h004;
  localparam int          PCL_ADDR_W        = 12;

  // ==========================================================
  // pll_control fields
  localparam int PCL_CME_BIT   = 7;
  localparam int PCL_PLL_POWER_ON_BIT = 6;
  localparam int PCL_AUTO_BIT  = 5;
  localparam int PCL_ACQ_BIT   = 4;
  localparam int PCL_RSVD_BIT  = 3;
  localparam int PCL_TICK_BIT  = 2;
  localparam int PCL_WDOG_BIT  = 1;
  localparam int PCL_LIMP_BIT  = 0;

  localparam logic [7:0] PCL_CTRL_RESET = 8'hf1;
  localparam logic [7:0] PCL_CTRL_MASK  = 8'hf7;

  // ==========================================================
  // status fields
  localparam int PCL_ST_LIMP_ACTIVE = 0;
  localparam int PCL_ST_PLL_SYSCLK  = 1;
  localparam int PCL_ST_HALT_WAIT   = 2;
  localparam int PCL_ST_OSC_KEEP    = 3;
  localparam int PCL_ST_STOP        = 4;
  localparam int PCL_ST_NEAR        = 5;
  localparam int PCL_ST_MON_ACTIVE  = 6;
  localparam int PCL_ST_LIMP_WRITTEN = 7;

  // ==========================================================
  // ahb-lite encodings
  localparam logic [1:0] PCL_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PCL_HTRANS_SEQ    = 2'h3;

  // word address compare on the low address bits
  function automatic logic pcl_hit(input logic [PCL_ADDR_W-1:0] addr,
                                   input logic [11:0] offset);
    pcl_hit = (addr[PCL_ADDR_W-1:2] == offset[PCL_ADDR_W-1:2]);
  endfunction

endpackage

`default_nettype wire

// file: hdl/pcl_sync2.sv
/*
  pcl_sync2: two flip-flop synchroniser for one level.
  assumes: the input is asynchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module pcl_sync2
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic asyncIn,
  output var  logic syncOut
);

  typedef struct packed
  {
    logic stage1;
    logic stage2;
  } pcl_sync_state_t;

  pcl_sync_state_t state_reg;
  pcl_sync_state_t state_next;

  // ==========================================================
  // capture chain
  always_comb
  begin
    state_next        = state_reg;
    state_next.stage1 = asyncIn;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign syncOut = state_reg.stage2;

endmodule

`default_nettype wire

// file: hdl/pcl_fail_action.sv
/*
  pcl_fail_action: clock monitor gating and the reaction to a failed
  crystal clock (monitor reset request or limp clock entry request).
  assumes: failure level already synchronised to mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module pcl_fail_action
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic failSync,
  input  wire logic monitorEnable,
  input  wire logic stopActive,
  input  wire logic oscKeepInStop,
  input  wire logic limpEnable,
  input  wire logic limpActive,
  output var  logic monitorActive,
  output var  logic monitorResetReq,
  output var  logic limpEnterReq
);

  typedef struct packed
  {
    logic active;
    logic failSeen;
    logic resetReq;
    logic limpReq;
  } pcl_fail_state_t;

  pcl_fail_state_t state_reg;
  pcl_fail_state_t state_next;
  logic            monOn;
  logic            failNew;

  // ==========================================================
  // monitor gating and failure reaction
  always_comb
  begin
    state_next        = state_reg;
    monOn             = monitorEnable && !(stopActive && !oscKeepInStop);
    failNew           = monOn && failSync && !state_reg.failSeen;
    state_next.active = monOn;
    state_next.failSeen = monOn && failSync;
    state_next.resetReq = failNew && !limpEnable;
    state_next.limpReq  = failNew && limpEnable && !limpActive;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign monitorActive   = state_reg.active;
  assign monitorResetReq = state_reg.resetReq;
  assign limpEnterReq    = state_reg.limpReq;

endmodule

`default_nettype wire

// file: sim/pcl_top_chk.sv
/*
  pcl_top_chk: port assertions for pcl_top.
  assumes: one slave on the bus, hready fed from hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none

module pcl_top_chk
  import pcl_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        limpClockActive,
  input wire logic        pllHaltInWait,
  input wire logic        oscKeepInStop,
  input wire logic        stopActive,
  input wire logic        pllPowerOut,
  input wire logic        wideFilterOut,
  input wire logic        autoBandwidthOut,
  input wire logic        tickDividerRun,
  input wire logic        watchdogDividerRun,
  input wire logic        monitorActive,
  input wire logic        monitorResetReq,
  input wire logic        limpEnterReq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ==========================================================
  // properties
  sequence s_ctrl(logic w);
    hsel && hready && htrans == PCL_HTRANS_NONSEQ && hwrite == w && haddr[11:2] == 10'h000;
  endsequence
  property p_limpPower;
    limpClockActive |=> pllPowerOut;
  endproperty
  property p_tickRun;
    !(stopActive && oscKeepInStop) |=> tickDividerRun;
  endproperty
  property p_wdogRun;
    !(stopActive && oscKeepInStop) |=> watchdogDividerRun;
  endproperty
  property p_fullStop;
    stopActive && !oscKeepInStop |=> !monitorActive;
  endproperty
  property p_haltAuto;
    pllHaltInWait [*2] |=> autoBandwidthOut;
  endproperty
  property p_manual;
    s_ctrl(1'b1) ##1 (hwdata[5:4] == 2'b01 && !pllHaltInWait) |-> ##2 wideFilterOut && !autoBandwidthOut;
  endproperty
  property p_haltWrite;
    s_ctrl(1'b1) ##1 (pllHaltInWait && !hwdata[5]) |-> ##2 autoBandwidthOut;
  endproperty
  property p_rsvdRead;
    s_ctrl(1'b0) |=> hrdata[31:8] == 24'h000000 && !hrdata[3];
  endproperty
  property p_pulse;
    (monitorResetReq || limpEnterReq) |-> !(monitorResetReq && limpEnterReq) ##1 !(monitorResetReq || limpEnterReq);
  endproperty

  // ==========================================================
  // assertions
  a_limpPower: assert property (p_limpPower) else $error("pll not forced on in limp mode");
  a_tickRun: assert property (p_tickRun) else $error("tick divider stopped outside pseudo-stop");
  a_wdogRun: assert property (p_wdogRun) else $error("watchdog divider stopped outside pseudo-stop");
  a_fullStop: assert property (p_fullStop) else $error("monitor active in full stop");
  a_haltAuto: assert property (p_haltAuto) else $error("auto bandwidth not forced");
  a_manual: assert property (p_manual) else $error("manual filter select wrong");
  a_haltWrite: assert property (p_haltWrite) else $error("auto bit cleared during halt in wait");
  a_rsvdRead: assert property (p_rsvdRead) else $error("reserved bits read nonzero");
  a_pulse: assert property (p_pulse) else $error("failure pulses overlap or stretch");

  c_monRst: cover property (monitorResetReq);
  c_limpReq: cover property (limpEnterReq);
  c_tickStop: cover property (!tickDividerRun);
endmodule

bind pcl_top pcl_top_chk u_chk (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .limpClockActive(limpClockActive), .pllHaltInWait(pllHaltInWait),
  .oscKeepInStop(oscKeepInStop), .stopActive(stopActive), .pllPowerOut(pllPowerOut),
  .wideFilterOut(wideFilterOut), .autoBandwidthOut(autoBandwidthOut),
  .tickDividerRun(tickDividerRun), .watchdogDividerRun(watchdogDividerRun),
  .monitorActive(monitorActive), .monitorResetReq(monitorResetReq), .limpEnterReq(limpEnterReq));

`default_nettype wire

// file: sim/pcl_top_tb.sv
/*
  pcl_top_tb: directed bench for the pll control register block.
  assumes: the bench is the only ahb-lite master and drives all mode inputs.
*/
`timescale 1ns/1ps
`default_nettype none

module pcl_top_tb;
  import pcl_pkg::*;
  localparam logic [31:0] CTRL = 32'(PCL_CTRL_OFFSET);
  logic        mclk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, l;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, limpClockActive = 1'b0, pllAsSystemClock = 1'b0;
  logic        pllHaltInWait = 1'b0, oscKeepInStop = 1'b0, stopActive = 1'b0;
  logic        specialMode = 1'b0, crystalFailAsync = 1'b0, vcoNearTargetAsync = 1'b0;
  logic        pllPowerOut, wideFilterOut, autoBandwidthOut, tickDividerRun;
  logic        watchdogDividerRun, monitorActive, monitorResetReq, limpEnterReq;
  int          failCount = 0, comparisons = 0;

  always #2 mclk = ~mclk;

  pcl_top dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .limpClockActive(limpClockActive),
    .pllAsSystemClock(pllAsSystemClock), .pllHaltInWait(pllHaltInWait),
    .oscKeepInStop(oscKeepInStop), .stopActive(stopActive), .specialMode(specialMode),
    .crystalFailAsync(crystalFailAsync), .vcoNearTargetAsync(vcoNearTargetAsync),
    .pllPowerOut(pllPowerOut), .wideFilterOut(wideFilterOut),
    .autoBandwidthOut(autoBandwidthOut), .tickDividerRun(tickDividerRun),
    .watchdogDividerRun(watchdogDividerRun), .monitorActive(monitorActive),
    .monitorResetReq(monitorResetReq), .limpEnterReq(limpEnterReq));

  // ==========================================================
  // helpers
  task automatic summarize();
    if (failCount == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      failCount++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= PCL_HTRANS_NONSEQ;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    r = hrdata;
    chk(hresp, 1'b0);
    hsel <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cnt();
    r = 0;
    l = 0;
    repeat (12)
    begin
      wt(1);
      r = r + monitorResetReq;
      l = l + limpEnterReq;
    end
  endtask
  task automatic doReset();
    reset <= 1'b1;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
  endtask

  // ==========================================================
  // scenarios
  task automatic tReset();
    rdc(CTRL, 32'hf1);
    rdc(32'h10, 32'h0);
    rdc(32'(PCL_STATUS_OFFSET), 32'h40);
    chk({pllPowerOut, wideFilterOut, autoBandwidthOut, tickDividerRun, watchdogDividerRun,
         monitorActive, monitorResetReq, limpEnterReq}, 8'hfc);
  endtask
  task automatic tBits();
    bus(1'b1, CTRL, 32'h08);
    rdc(CTRL, 32'h00);
    wt(2);
    chk({pllPowerOut, wideFilterOut, autoBandwidthOut, monitorActive}, 4'h0);
    bus(1'b1, CTRL, 32'h11);
    rdc(CTRL, 32'h10);
    wt(2);
    chk(wideFilterOut, 1'b1);
  endtask
  task automatic tGuards();
    pllAsSystemClock <= 1'b1;
    bus(1'b1, CTRL, 32'h50);
    rdc(CTRL, 32'h10);
    pllAsSystemClock <= 1'b0;
    pllHaltInWait <= 1'b1;
    bus(1'b1, CTRL, 32'h10);
    rdc(CTRL, 32'h30);
    wt(2);
    chk(autoBandwidthOut, 1'b1);
    pllHaltInWait <= 1'b0;
    bus(1'b1, CTRL, 32'h40);
    rdc(CTRL, 32'h40);
    wt(2);
    chk(pllPowerOut, 1'b1);
  endtask
  task automatic tAuto();
    bus(1'b1, CTRL, 32'h70);
    vcoNearTargetAsync <= 1'b1;
    wt(6);
    chk({autoBandwidthOut, wideFilterOut}, 2'b10);
    vcoNearTargetAsync <= 1'b0;
    wt(6);
    chk(wideFilterOut, 1'b1);
  endtask
  task automatic tPseudo();
    bus(1'b1, CTRL, 32'h02);
    stopActive <= 1'b1;
    oscKeepInStop <= 1'b1;
    wt(2);
    chk({tickDividerRun, watchdogDividerRun}, 2'b01);
    bus(1'b1, CTRL, 32'h04);
    wt(2);
    chk({tickDividerRun, watchdogDividerRun}, 2'b10);
    oscKeepInStop <= 1'b0;
    wt(2);
    chk({tickDividerRun, watchdogDividerRun}, 2'b11);
    stopActive <= 1'b0;
  endtask
  task automatic tFail();
    bus(1'b1, CTRL, 32'h80);
    wt(3);
    chk(monitorActive, 1'b1);
    crystalFailAsync <= 1'b1;
    cnt();
    chk({r[3:0], l[3:0]}, 8'h10);
    crystalFailAsync <= 1'b0;
    stopActive <= 1'b1;
    wt(4);
    chk(monitorActive, 1'b0);
    crystalFailAsync <= 1'b1;
    cnt();
    chk({r[3:0], l[3:0]}, 8'h00);
    crystalFailAsync <= 1'b0;
    stopActive <= 1'b0;
    wt(4);
  endtask
  task automatic tLimp();
    doReset();
    bus(1'b1, CTRL, 32'h80);
    rdc(CTRL, 32'h80);
    specialMode <= 1'b1;
    bus(1'b1, CTRL, 32'h81);
    wt(3);
    crystalFailAsync <= 1'b1;
    cnt();
    chk({r[3:0], l[3:0]}, 8'h01);
    crystalFailAsync <= 1'b0;
    limpClockActive <= 1'b1;
    bus(1'b1, CTRL, 32'h00);
    rdc(CTRL, 32'h81);
    wt(2);
    chk(pllPowerOut, 1'b1);
    limpClockActive <= 1'b0;
    bus(1'b1, CTRL, 32'h00);
    rdc(CTRL, 32'h00);
    wt(2);
    chk(pllPowerOut, 1'b0);
  endtask

  initial
  begin
    doReset();
    tReset();
    tBits();
    tGuards();
    tAuto();
    tPseudo();
    tFail();
    tLimp();
    summarize();
  end

  initial
  begin
    #20000;
    failCount++;
    summarize();
  end
endmodule

`default_nettype wire
